/* File: rtl/scc_top.sv */
// System clock configuration registers and clock control outputs behind an APB slave
`timescale 1ns/1ps
module scc_top
   import scc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] powerMode,
   output logic [1:0] gateSetSel,
   output logic pllPowerDown,
   output logic pllSkip,
   output logic dividerUse,
   output logic [5:0] divideBy,
   output logic [2:0] oscillatorSelect,
   output logic internalOscOff,
   output logic mainOscOff,
   output logic [8:0] pllMultiplier,
   output logic [4:0] pllInputDivider
);
   // ****************************************
   // Register storage
   // ****************************************
   logic [31:0] runCfg_q;
   logic [31:0] extCfg_q;
   logic [31:0] pllFactor_q;
   logic [3:0] lastCrystal_q;
   logic factorLoaded_q;
   logic [31:0] wrMask;
   logic access;
   logic hit;
   logic [5:0] rawDiv;
   logic [5:0] effDiv;
   logic extSel;
   scc_factor_if fac ();

   // APB decode; single-cycle answer, error on unmapped or write to read-only
   assign access = psel && penable;
   assign hit = (paddr == SCC_OFF_RUN_CFG) || (paddr == SCC_OFF_PLL_FACTOR) ||
      (paddr == SCC_OFF_RUN_CFG_EXT);
   assign pready = 1'b1;
   assign pslverr = access && (!hit || (pwrite && paddr == SCC_OFF_PLL_FACTOR));
   assign wrMask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

   // Original configuration register; reserved bits keep reset value
   always_ff @(posedge clk) begin
      if (reset) begin
         runCfg_q <= SCC_RUN_RESET;
      end else if (access && pwrite && paddr == SCC_OFF_RUN_CFG) begin
         runCfg_q <= (runCfg_q & ~(SCC_RUN_WMASK & wrMask)) |
            (pwdata & SCC_RUN_WMASK & wrMask);
      end
   end

   // Extended configuration register, with a select bit and wider oscillator select and divisor fields
   always_ff @(posedge clk) begin
      if (reset) begin
         extCfg_q <= SCC_EXT_RESET;
      end else if (access && pwrite && paddr == SCC_OFF_RUN_CFG_EXT) begin
         extCfg_q <= (extCfg_q & ~(SCC_EXT_WMASK & wrMask)) |
            (pwdata & SCC_EXT_WMASK & wrMask);
      end
   end

   // Factor lookup from the active crystal code
   assign fac.crystalFreqCode = runCfg_q[9:6];
   scc_factor_table u_table (
      .fac(fac.table_side)
   );

   // Factor register loaded after reset and on every crystal code change
   always_ff @(posedge clk) begin
      if (reset) begin
         pllFactor_q <= SCC_PLL_FACTOR_RESET;
         lastCrystal_q <= 4'h0;
         factorLoaded_q <= 1'b0;
      end else if (!factorLoaded_q || lastCrystal_q != runCfg_q[9:6]) begin
         pllFactor_q <= {18'h00000, fac.multiplier, fac.inputDivider};
         lastCrystal_q <= runCfg_q[9:6];
         factorLoaded_q <= 1'b1;
      end
   end

   // Read mux
   always_ff @(posedge clk) begin
      if (reset) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            SCC_OFF_RUN_CFG: prdata <= runCfg_q;
            SCC_OFF_PLL_FACTOR: prdata <= pllFactor_q;
            SCC_OFF_RUN_CFG_EXT: prdata <= extCfg_q;
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ****************************************
   // Clock control outputs
   // ****************************************
   assign extSel = extCfg_q[SCC_B_EXTSEL];

   // Field selection between original and extended register
   always_comb begin
      if (extSel) begin
         pllPowerDown = extCfg_q[SCC_B_PLL_POWER_DOWN];
         pllSkip = extCfg_q[SCC_B_SKIP];
         oscillatorSelect = extCfg_q[6:4];
         rawDiv = extCfg_q[28:23];
      end else begin
         pllPowerDown = runCfg_q[SCC_B_PLL_POWER_DOWN];
         pllSkip = runCfg_q[SCC_B_SKIP];
         oscillatorSelect = {1'b0, runCfg_q[5:4]};
         rawDiv = {2'b00, runCfg_q[26:23]};
      end
   end

   // Minimum divisor substitution when the PLL drives the clock
   assign effDiv = (!pllSkip && rawDiv < SCC_MIN_DIV) ? SCC_MIN_DIV : rawDiv;
   assign divideBy = effDiv; // code n divides by n+1
   assign dividerUse = runCfg_q[SCC_B_DIVUSE] || !pllSkip;
   assign internalOscOff = runCfg_q[SCC_B_IOFF];
   assign mainOscOff = runCfg_q[SCC_B_MOFF];
   assign pllMultiplier = pllFactor_q[13:5];
   assign pllInputDivider = pllFactor_q[4:0];

   // Gating set choice by power mode
   always_comb begin
      case (powerMode)
         SCC_MODE_RUN: gateSetSel = SCC_MODE_RUN;
         SCC_MODE_SLEEP: gateSetSel = runCfg_q[SCC_B_ACG] ? SCC_MODE_SLEEP : SCC_MODE_RUN;
         SCC_MODE_DEEP: gateSetSel = runCfg_q[SCC_B_ACG] ? SCC_MODE_DEEP : SCC_MODE_RUN;
         default: gateSetSel = SCC_MODE_RUN;
      endcase
   end

   // ****************************************
   // Assertions
   // ****************************************
   property p_run_gate;
      @(posedge clk) disable iff (reset) powerMode == SCC_MODE_RUN |-> gateSetSel == SCC_MODE_RUN;
   endproperty
   a_run_gate: assert property (p_run_gate) else $error("run mode not on run set");

   property p_sleep_gate;
      @(posedge clk) disable iff (reset)
         powerMode == SCC_MODE_SLEEP |-> gateSetSel == (runCfg_q[SCC_B_ACG] ? 2'h1 : 2'h0);
   endproperty
   a_sleep_gate: assert property (p_sleep_gate) else $error("sleep gating set wrong");

   property p_min_div;
      @(posedge clk) disable iff (reset) !pllSkip |-> divideBy >= SCC_MIN_DIV;
   endproperty
   a_min_div: assert property (p_min_div) else $error("divisor below minimum");

   property p_div_use;
      @(posedge clk) disable iff (reset) !pllSkip |-> dividerUse;
   endproperty
   a_div_use: assert property (p_div_use) else $error("divider not used with PLL");

   property p_reset_vals;
      @(posedge clk) $fell(reset) |-> pllPowerDown && pllSkip && mainOscOff && divideBy == 6'h0F;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

   sequence s_crystal_freq_code_change;
      !reset && $changed(runCfg_q[9:6]);
   endsequence
   property p_factor_reload;
      @(posedge clk) disable iff (reset)
         s_crystal_freq_code_change |-> ##1 pllFactor_q[13:0] == {fac.multiplier, fac.inputDivider};
   endproperty
   a_factor_reload: assert property (p_factor_reload) else $error("factor not reloaded");

   property p_factor_rsvd;
      @(posedge clk) disable iff (reset) pllFactor_q[31:14] == 18'h00000;
   endproperty
   a_factor_rsvd: assert property (p_factor_rsvd) else $error("factor reserved bits set");

   property p_rsvd;
      @(posedge clk) disable iff (reset)
         ((runCfg_q & ~SCC_RUN_WMASK) == (SCC_RUN_RESET & ~SCC_RUN_WMASK)) &&
         ((extCfg_q & ~SCC_EXT_WMASK) == (SCC_EXT_RESET & ~SCC_EXT_WMASK));
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits changed");

   property p_ext_sel;
      @(posedge clk) disable iff (reset) extSel |-> pllSkip == extCfg_q[SCC_B_SKIP] &&
         pllPowerDown == extCfg_q[SCC_B_PLL_POWER_DOWN];
   endproperty
   a_ext_sel: assert property (p_ext_sel) else $error("extended fields not used");

   // Deep sleep follows the auto gating bit
   property p_deep_gate;
      @(posedge clk) disable iff (reset)
         powerMode == SCC_MODE_DEEP |-> gateSetSel == (runCfg_q[SCC_B_ACG] ? 2'h2 : 2'h0);
   endproperty
   a_deep_gate: assert property (p_deep_gate) else $error("deep gating set wrong");

   // Unused mode code behaves as run
   property p_spare_mode;
      @(posedge clk) disable iff (reset) powerMode == 2'h3 |-> gateSetSel == SCC_MODE_RUN;
   endproperty
   a_spare_mode: assert property (p_spare_mode) else $error("spare mode not on run set");

   // Bypassed clock passes the programmed original divisor
   property p_bypass_div;
      @(posedge clk) disable iff (reset)
         pllSkip && !extSel |-> divideBy == {2'b00, runCfg_q[26:23]};
   endproperty
   a_bypass_div: assert property (p_bypass_div) else $error("bypass divisor wrong");

   // Divisors at or above the minimum pass unchanged
   property p_div_pass;
      @(posedge clk) disable iff (reset) !pllSkip && rawDiv >= SCC_MIN_DIV |-> divideBy == rawDiv;
   endproperty
   a_div_pass: assert property (p_div_pass) else $error("legal divisor altered");

   // Divider-use bit alone enables the divider
   property p_div_bit;
      @(posedge clk) disable iff (reset) runCfg_q[SCC_B_DIVUSE] |-> dividerUse;
   endproperty
   a_div_bit: assert property (p_div_bit) else $error("divider-use bit ignored");

   // Original power-down bit drives the PLL directly
   property p_pll_power_down_orig;
      @(posedge clk) disable iff (reset) !extSel |-> pllPowerDown == runCfg_q[SCC_B_PLL_POWER_DOWN];
   endproperty
   a_pll_power_down_orig: assert property (p_pll_power_down_orig) else $error("power-down not from original");

   // Original skip bit picks oscillator or PLL
   property p_skip_orig;
      @(posedge clk) disable iff (reset) !extSel |-> pllSkip == runCfg_q[SCC_B_SKIP];
   endproperty
   a_skip_orig: assert property (p_skip_orig) else $error("skip not from original");

   // Original oscillator select reaches the clock mux
   property p_osc_orig;
      @(posedge clk) disable iff (reset) !extSel |-> oscillatorSelect == {1'b0, runCfg_q[5:4]};
   endproperty
   a_osc_orig: assert property (p_osc_orig) else $error("oscillator select wrong");

   // Internal oscillator off follows its bit
   property p_ioff;
      @(posedge clk) disable iff (reset) internalOscOff == runCfg_q[SCC_B_IOFF];
   endproperty
   a_ioff: assert property (p_ioff) else $error("internal oscillator off wrong");

   // Main oscillator off follows its bit
   property p_moff;
      @(posedge clk) disable iff (reset) mainOscOff == runCfg_q[SCC_B_MOFF];
   endproperty
   a_moff: assert property (p_moff) else $error("main oscillator off wrong");

   // Crystal code held for two edges, so the factor has caught up
   sequence s_crystal_freq_code_settled;
      $stable(runCfg_q[9:6]) ##1 $stable(runCfg_q[9:6]);
   endsequence
   property p_crystal_freq_code_rsvd;
      @(posedge clk) disable iff (reset)
         s_crystal_freq_code_settled |-> (runCfg_q[9:6] < 4'h4) == (pllFactor_q[13:5] == 9'h000);
   endproperty
   a_crystal_freq_code_rsvd: assert property (p_crystal_freq_code_rsvd) else $error("reserved crystal factor wrong");

   // Settled factor matches the lookup of the current code
   property p_factor_match;
      @(posedge clk) disable iff (reset)
         s_crystal_freq_code_settled |-> pllFactor_q[13:0] == {fac.multiplier, fac.inputDivider};
   endproperty
   a_factor_match: assert property (p_factor_match) else $error("factor stale");

   // Factor outputs come straight from the register fields
   property p_factor_out;
      @(posedge clk) disable iff (reset)
         pllMultiplier == pllFactor_q[13:5] && pllInputDivider == pllFactor_q[4:0];
   endproperty
   a_factor_out: assert property (p_factor_out) else $error("factor outputs wrong");

   // Extended oscillator select uses the wider field
   property p_ext_osc;
      @(posedge clk) disable iff (reset) extSel |-> oscillatorSelect == extCfg_q[6:4];
   endproperty
   a_ext_osc: assert property (p_ext_osc) else $error("extended oscillator wrong");

   // Extended divisor passes in full when bypassed
   property p_ext_div;
      @(posedge clk) disable iff (reset) extSel && pllSkip |-> divideBy == extCfg_q[28:23];
   endproperty
   a_ext_div: assert property (p_ext_div) else $error("extended divisor wrong");

   // Full-word write to the original register lands in writable bits
   sequence s_orig_write;
      access && pwrite && paddr == SCC_OFF_RUN_CFG && pstrb == 4'hF;
   endsequence
   property p_write_orig;
      @(posedge clk) disable iff (reset)
         s_orig_write |=> (runCfg_q & SCC_RUN_WMASK) == ($past(pwdata) & SCC_RUN_WMASK);
   endproperty
   a_write_orig: assert property (p_write_orig) else $error("original write lost");

   // Full-word write to the extended register lands in writable bits
   sequence s_ext_write;
      access && pwrite && paddr == SCC_OFF_RUN_CFG_EXT && pstrb == 4'hF;
   endsequence
   property p_write_ext;
      @(posedge clk) disable iff (reset)
         s_ext_write |=> (extCfg_q & SCC_EXT_WMASK) == ($past(pwdata) & SCC_EXT_WMASK);
   endproperty
   a_write_ext: assert property (p_write_ext) else $error("extended write lost");

   // Writes to the factor register are refused with an error
   property p_ro_write;
      @(posedge clk) disable iff (reset)
         access && pwrite && paddr == SCC_OFF_PLL_FACTOR |-> pslverr;
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("factor write not refused");

   // Unmapped addresses answer with an error
   property p_unmapped;
      @(posedge clk) disable iff (reset) access && !hit |-> pslverr;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

   // Read data in the access cycle is the register seen at setup
   sequence s_read_orig;
      psel && !penable && !pwrite && paddr == SCC_OFF_RUN_CFG ##1 access;
   endsequence
   property p_read_orig;
      @(posedge clk) disable iff (reset) s_read_orig |-> prdata == $past(runCfg_q);
   endproperty
   a_read_orig: assert property (p_read_orig) else $error("read data wrong");

   // Oscillator fields come out of reset on the internal oscillator
   property p_reset_osc;
      @(posedge clk) $fell(reset) |-> oscillatorSelect == 3'h1 && !internalOscOff && !dividerUse;
   endproperty
   a_reset_osc: assert property (p_reset_osc) else $error("reset oscillator wrong");
endmodule

/* File: rtl/scc_pkg.sv */
// Package of offsets, fields, reset values and selection codes for the system clock configuration block
package scc_pkg;
   // ****************************************
   // Register offsets (byte addresses)
   // ****************************************
   localparam logic [11:0] SCC_OFF_RUN_CFG = 12'h060;
   localparam logic [11:0] SCC_OFF_PLL_FACTOR = 12'h064;
   localparam logic [11:0] SCC_OFF_RUN_CFG_EXT = 12'h070;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int SCC_B_EXTSEL = 31;
   localparam int SCC_B_ACG = 27;
   localparam int SCC_B_DIVUSE = 22;
   localparam int SCC_B_PLL_POWER_DOWN = 13;
   localparam int SCC_B_SKIP = 11;
   localparam int SCC_B_IOFF = 1;
   localparam int SCC_B_MOFF = 0;
   // ****************************************
   // Writable masks and reset values
   // ****************************************
   localparam logic [31:0] SCC_RUN_WMASK = 32'h0FC0_2BF3;
   localparam logic [31:0] SCC_RUN_RESET = 32'h0780_3AD1;
   localparam logic [31:0] SCC_EXT_WMASK = 32'h9F80_2870;
   localparam logic [31:0] SCC_EXT_RESET = 32'h0780_2810;
   // ****************************************
   // Divisor limits
   // ****************************************
   localparam logic [5:0] SCC_MIN_DIV = 6'h03;
   localparam logic [5:0] SCC_WIDE_MAX = 6'h3F;
   // ****************************************
   // Clock selection codes
   // ****************************************
   typedef enum logic [2:0] {
      SCC_SRC_MAIN = 3'h0,
      SCC_SRC_INT = 3'h1,
      SCC_SRC_INT4 = 3'h2,
      SCC_SRC_SLOW = 3'h3
   } scc_src_t;
   typedef enum logic [1:0] {
      SCC_MODE_RUN = 2'h0,
      SCC_MODE_SLEEP = 2'h1,
      SCC_MODE_DEEP = 2'h2
   } scc_mode_t;
   localparam logic [31:0] SCC_PLL_FACTOR_RESET = 32'h0000_0000;
endpackage

/* File: rtl/scc_factor_if.sv */
// Interface carrying the crystal code to the PLL factor lookup and its result back
`timescale 1ns/1ps
interface scc_factor_if;
   logic [3:0] crystalFreqCode;
   logic [8:0] multiplier;
   logic [4:0] inputDivider;
   modport table_side (input crystalFreqCode, output multiplier, output inputDivider);
   modport user_side (output crystalFreqCode, input multiplier, input inputDivider);
endinterface

/* File: rtl/scc_factor_table.sv */
// Lookup of PLL multiplier and input divider from the crystal frequency code
`timescale 1ns/1ps
module scc_factor_table
   import scc_pkg::*;
(
   scc_factor_if.table_side fac
);
   // Factors give 400 MHz from each crystal; reserved codes give zero
   always_comb begin
      case (fac.crystalFreqCode)
         4'h4: begin fac.multiplier = 9'h1BF; fac.inputDivider = 5'h03; end
         4'h5: begin fac.multiplier = 9'h0D9; fac.inputDivider = 5'h01; end
         4'h6: begin fac.multiplier = 9'h064; fac.inputDivider = 5'h00; end
         4'h7: begin fac.multiplier = 9'h0C3; fac.inputDivider = 5'h01; end
         4'h8: begin fac.multiplier = 9'h145; fac.inputDivider = 5'h03; end
         4'h9: begin fac.multiplier = 9'h050; fac.inputDivider = 5'h00; end
         4'hA: begin fac.multiplier = 9'h09C; fac.inputDivider = 5'h01; end
         4'hB: begin fac.multiplier = 9'h0C8; fac.inputDivider = 5'h02; end
         4'hC: begin fac.multiplier = 9'h104; fac.inputDivider = 5'h03; end
         4'hD: begin fac.multiplier = 9'h0D9; fac.inputDivider = 5'h03; end
         4'hE: begin fac.multiplier = 9'h032; fac.inputDivider = 5'h00; end
         4'hF: begin fac.multiplier = 9'h0C3; fac.inputDivider = 5'h03; end
         default: begin fac.multiplier = 9'h000; fac.inputDivider = 5'h00; end
      endcase
   end
endmodule

/* File: test/tb_top.sv */
// Self-checking testbench of the system clock configuration block
`timescale 1ns/1ps
module tb_top import scc_pkg::*; ();
   logic clk, reset, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, origQ, extQ, rnd, rd, fac;
   logic [3:0] pstrb;
   logic [1:0] powerMode, gateSetSel;
   logic pllPowerDown, pllSkip, dividerUse, internalOscOff, mainOscOff;
   logic [5:0] divideBy;
   logic [2:0] oscillatorSelect;
   logic [8:0] pllMultiplier;
   logic [4:0] pllInputDivider;
   int nMismatch = 0;
   int testsRun = 0;
   scc_top dut_u (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .powerMode(powerMode), .gateSetSel(gateSetSel),
      .pllPowerDown(pllPowerDown), .pllSkip(pllSkip), .dividerUse(dividerUse),
      .divideBy(divideBy), .oscillatorSelect(oscillatorSelect),
      .internalOscOff(internalOscOff), .mainOscOff(mainOscOff),
      .pllMultiplier(pllMultiplier), .pllInputDivider(pllInputDivider));
   // ****************************************
   // Clock and helpers
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // PLL output from crystal code and factor must land near 400 MHz
   function automatic logic pll_ok(input int c, input logic [31:0] r);
      longint hz;
      longint f;
      case (c)
         4: hz = 3579545;
         5: hz = 3686400;
         6: hz = 4000000;
         7: hz = 4096000;
         8: hz = 4915200;
         9: hz = 5000000;
         10: hz = 5120000;
         11: hz = 6000000;
         12: hz = 6144000;
         13: hz = 7372800;
         14: hz = 8000000;
         15: hz = 8192000;
         default: hz = 0;
      endcase
      f = hz * longint'(r[13:5]) / (longint'(r[4:0]) + 1);
      return (f > 399000000) && (f < 401000000);
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp) begin
         nMismatch++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", testsRun, nMismatch);
      if (nMismatch == 0 && testsRun > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // APB transfer: setup, access held until pready, then release
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         nMismatch++;
         complete_run();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // Compares the gating set in all power modes, then the divisor, PLL, divider and oscillator outputs, with the model
   task automatic check_outs();
      logic x, sk;
      logic [5:0] dv;
      x = extQ[31];
      sk = x ? extQ[11] : origQ[11];
      dv = x ? extQ[28:23] : {2'b00, origQ[26:23]};
      if (!sk && dv < 6'h03) dv = 6'h03;
      for (int m = 0; m < 4; m++) begin
         powerMode <= 2'(m);
         @(posedge clk);
         chk(gateSetSel, (origQ[27] && (m == 1 || m == 2)) ? m : 0);
      end
      chk(divideBy, dv);
      chk(pllSkip, sk);
      chk(pllPowerDown, x ? extQ[13] : origQ[13]);
      chk(dividerUse, origQ[22] | !sk);
      chk(oscillatorSelect, x ? extQ[6:4] : {1'b0, origQ[5:4]});
      chk({internalOscOff, mainOscOff}, origQ[1:0]);
   endtask
   // Write, update the model, read back and check outputs
   task automatic step(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      chk(err, 0);
      if (a == SCC_OFF_RUN_CFG) origQ = (origQ & ~SCC_RUN_WMASK) | (d & SCC_RUN_WMASK);
      else extQ = (extQ & ~SCC_EXT_WMASK) | (d & SCC_EXT_WMASK);
      apb(1'b0, a, 32'h0);
      chk(rd, a == SCC_OFF_RUN_CFG ? origQ : extQ);
      check_outs();
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hF;
      powerMode = 2'h0;
      rnd = 32'h91A43F52;
      origQ = 32'h0780_3AD1;
      extQ = 32'h0780_2810;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      apb(1'b0, SCC_OFF_RUN_CFG, 32'h0);
      chk(rd, 32'h0780_3AD1);
      apb(1'b0, SCC_OFF_RUN_CFG_EXT, 32'h0);
      chk(rd, 32'h0780_2810);
      check_outs();
      apb(1'b0, SCC_OFF_PLL_FACTOR, 32'h0);
      chk(pll_ok(11, rd), 1);
      $display("Reset values test done");
      step(SCC_OFF_RUN_CFG, 32'h0880_02E0);
      step(SCC_OFF_RUN_CFG_EXT, 32'h9F80_0000);
      step(SCC_OFF_RUN_CFG_EXT, 32'h8000_0000);
      step(SCC_OFF_RUN_CFG_EXT, 32'h0000_0000);
      $display("Divisor limit test done");
      for (int i = 0; i < 24; i++) begin
         rnd = lfsr(rnd);
         step(rnd[3] ? SCC_OFF_RUN_CFG_EXT : SCC_OFF_RUN_CFG, lfsr(rnd));
      end
      $display("Random register test done");
      for (int c = 0; c < 16; c++) begin
         step(SCC_OFF_RUN_CFG, (origQ & ~32'h0000_03C0) | (32'(c) << 6));
         apb(1'b0, SCC_OFF_PLL_FACTOR, 32'h0);
         if (c < 4) chk(rd, 0);
         else chk(pll_ok(c, rd), 1);
         chk(rd, {18'h0, pllMultiplier, pllInputDivider});
      end
      $display("Crystal factor test done");
      fac = rd;
      apb(1'b1, SCC_OFF_PLL_FACTOR, 32'hFFFF_FFFF);
      chk(err, 1);
      apb(1'b0, SCC_OFF_PLL_FACTOR, 32'h0);
      chk(rd, fac);
      apb(1'b0, 12'h068, 32'h0);
      chk(rd, 0);
      chk(err, 1);
      $display("Refusal test done");
      complete_run();
   end
endmodule
